// ### src/mtmc_defines.svh
// constants for the timer mode-control block: offsets, fields, reset values
// Functional notes
// - sync register resets to 0xE0 on reset or standby; bits 7..5 read one
// - sync bit n set makes channel n join synchronous preset and clear
// - mode register resets to 0x80 on reset or standby; bit 7 reads one
// - mode bit 6 selects phase counting for channel 2 using phase pins
// - in phase counting, an edge of one phase pin counts once; edges on both pins in the same cycle are dropped
// - phase counting overrides channel 2 edge and prescaler clock selection
// - channel 2 clear, compare, capture and interrupts stay active in phase mode
// - mode bit 5 clear flags overflow or underflow; set flags overflow only
// - mode bits 4..0 enable pulse output on channels 4..0, default off
// - pulse pin goes high on match with A, low on match with B
// - complementary or reset-synchronised combination mode masks pulse enables 3 and 4
`ifndef MTMC_DEFINES_SVH
`define MTMC_DEFINES_SVH

//------------------------------------------------------------
// register map
//------------------------------------------------------------
`define MTMC_ADDR_W 8
`define MTMC_OFS_SYNC 8'h00
`define MTMC_OFS_MODE 8'h04
`define MTMC_OFS_STAT 8'h08
`define MTMC_OFS_MASK 8'h0c

//------------------------------------------------------------
// fields and reset values
//------------------------------------------------------------
`define MTMC_NUM_CH 5
`define MTMC_SYNC_RST 8'he0
`define MTMC_SYNC_RSV 3'h7
`define MTMC_MODE_RST 8'h80
`define MTMC_MODE_RSV 1'h1
`define MTMC_MODE_PHASE_BIT 6
`define MTMC_MODE_OVERFLOW_FLAG_DIRECTION_BIT 5
`define MTMC_STAT_OVF_BIT 0
`define MTMC_STAT_SYNC_BIT 1
`define MTMC_STAT_W 2
`define MTMC_RESP_OKAY 2'h0
`define MTMC_RESP_SLVERR 2'h2

`endif

// ### src/mtmc_pkg.sv
// types shared by the timer mode-control block
package mtmc_pkg;
  // combination mode field of channels 3 and 4
  typedef enum logic [1:0] {
    MTMC_COMB_NORMAL_A = 2'h0,
    MTMC_COMB_NORMAL_B = 2'h1,
    MTMC_COMB_COMPL = 2'h2,
    MTMC_COMB_RESET_SYNC = 2'h3
  } mtmc_comb_mode_type;
  typedef logic [4:0] mtmc_chan_vec_type;
endpackage

// ### src/mtmc_phase_decoder.sv
// two-phase edge decoder producing up and down count pulses
`timescale 1ns/1ps
module mtmc_phase_decoder (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  output logic count_up_out,
  output logic count_down_out
);
  logic prev_a;
  logic prev_b;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic next_up;
  logic next_down;

  // edges against last sampled level; history tracks even when disabled
  assign a_rise = phase_a_in & ~prev_a;
  assign a_fall = ~phase_a_in & prev_a;
  assign b_rise = phase_b_in & ~prev_b;
  assign b_fall = ~phase_b_in & prev_b;

  // one pin moving counts; both moving together is ambiguous and dropped
  always_comb begin
    next_down = 1'b0;
    next_up = 1'b0;
    if ((a_rise | a_fall) ^ (b_rise | b_fall)) begin
      next_down = (a_rise & ~phase_b_in) | (b_rise & phase_a_in)
        | (a_fall & phase_b_in) | (b_fall & ~phase_a_in);
      next_up = ~next_down;
    end
  end

  // level history
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
    end else begin
      prev_a <= phase_a_in;
      prev_b <= phase_b_in;
    end
  end

  // registered count pulses
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      count_up_out <= 1'b0;
      count_down_out <= 1'b0;
    end else begin
      count_up_out <= enable_in & next_up;
      count_down_out <= enable_in & next_down;
    end
  end
endmodule

// ### src/mtmc_pwm_out.sv
// per-channel pulse output pins driven by compare matches
`timescale 1ns/1ps
module mtmc_pwm_out #(
  parameter int NUM_CH = 5
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [NUM_CH-1:0] enable_in,
  input wire logic [NUM_CH-1:0] match_a_in,
  input wire logic [NUM_CH-1:0] match_b_in,
  output logic [NUM_CH-1:0] pin_out,
  output logic [NUM_CH-1:0] pin_oe_n_out
);
  // level: match with A sets, match with B clears and wins a tie
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pin_out <= '0;
    end else begin
      pin_out <= (pin_out | (enable_in & match_a_in)) & ~(enable_in & match_b_in);
    end
  end

  // pin driven (enable low) only while its pulse mode is on
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pin_oe_n_out <= '1;
    end else begin
      pin_oe_n_out <= ~enable_in;
    end
  end
endmodule

// ### src/mtmc_timer_mode_ctrl.sv
// timer mode control: sync select, mode select, irq and axi4-lite slave
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "mtmc_defines.svh"
module mtmc_timer_mode_ctrl (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic standby_in,
  // axi4-lite slave
  input wire logic [`MTMC_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [`MTMC_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // counter side
  input wire mtmc_pkg::mtmc_chan_vec_type preset_req_in,
  input wire mtmc_pkg::mtmc_chan_vec_type clear_req_in,
  output mtmc_pkg::mtmc_chan_vec_type preset_out,
  output mtmc_pkg::mtmc_chan_vec_type clear_out,
  input wire logic phase_input_a_in,
  input wire logic phase_input_b_in,
  input wire logic ch2_normal_tick_in,
  output logic ch2_count_up_out,
  output logic ch2_count_down_out,
  input wire logic ch2_overflow_in,
  input wire logic ch2_underflow_in,
  output logic overflow_flag_set_out,
  // pulse outputs
  input wire mtmc_pkg::mtmc_comb_mode_type comb_mode_in,
  input wire mtmc_pkg::mtmc_chan_vec_type match_a_in,
  input wire mtmc_pkg::mtmc_chan_vec_type match_b_in,
  output mtmc_pkg::mtmc_chan_vec_type compare_pin_a_out,
  output mtmc_pkg::mtmc_chan_vec_type compare_pin_a_oe_n_out,
  output logic irq_out
);
  import mtmc_pkg::*;

  //------------------------------------------------------------
  // declarations
  //------------------------------------------------------------
  mtmc_chan_vec_type channel_sync_select;
  logic phase_count_enable;
  logic overflow_flag_direction;
  mtmc_chan_vec_type pulse_mode;
  logic [`MTMC_STAT_W-1:0] irq_status;
  logic [`MTMC_STAT_W-1:0] irq_mask;
  logic aw_held;
  logic w_held;
  logic [`MTMC_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic do_write;
  logic wr_lane0;
  logic dec_up;
  logic dec_down;
  logic any_sync_preset;
  logic any_sync_clear;
  logic next_ovf_set;
  logic [`MTMC_STAT_W-1:0] next_events;
  logic comb_override;
  mtmc_chan_vec_type pwm_enable_eff;

  //------------------------------------------------------------
  // register decode helpers
  //------------------------------------------------------------
  // true for any word offset that holds a register
  function automatic logic addr_mapped(input logic [`MTMC_ADDR_W-1:0] addr);
    addr_mapped = (addr == `MTMC_OFS_SYNC) || (addr == `MTMC_OFS_MODE)
      || (addr == `MTMC_OFS_STAT) || (addr == `MTMC_OFS_MASK);
  endfunction

  // read value of one word; reserved bits read as documented
  function automatic logic [31:0] reg_value(input logic [`MTMC_ADDR_W-1:0] addr);
    reg_value = 32'h0000_0000;
    case (addr)
      `MTMC_OFS_SYNC: begin
        reg_value[7:0] = {`MTMC_SYNC_RSV, channel_sync_select};
      end
      `MTMC_OFS_MODE: begin
        reg_value[7:0] = {`MTMC_MODE_RSV, phase_count_enable, overflow_flag_direction,
          pulse_mode};
      end
      `MTMC_OFS_STAT: begin
        reg_value[`MTMC_STAT_W-1:0] = irq_status;
      end
      `MTMC_OFS_MASK: begin
        reg_value[`MTMC_STAT_W-1:0] = irq_mask;
      end
      default: begin
        reg_value = 32'h0000_0000;
      end
    endcase
  endfunction

  //------------------------------------------------------------
  // axi4-lite write channel
  //------------------------------------------------------------
  // address and data are held until the write is done and answered
  assign s_axi_awready_out = ~aw_held;
  assign s_axi_wready_out = ~w_held;
  assign do_write = aw_held & w_held & ~s_axi_bvalid_out;
  assign wr_lane0 = do_write & w_lane0 & addr_mapped(aw_addr);

  // address capture
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid_in && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // data capture
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid_in && !w_held) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_lane0 <= s_axi_wstrb_in[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `MTMC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= addr_mapped(aw_addr) ? `MTMC_RESP_OKAY : `MTMC_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // axi4-lite read channel
  //------------------------------------------------------------
  assign s_axi_arready_out = ~s_axi_rvalid_out;

  // read data and response, one cycle after the address is taken
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `MTMC_RESP_OKAY;
    end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= reg_value(s_axi_araddr_in);
      s_axi_rresp_out <= addr_mapped(s_axi_araddr_in) ? `MTMC_RESP_OKAY : `MTMC_RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // control registers
  //------------------------------------------------------------
  // sync select: reset and standby both restore the initial value
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || standby_in) begin
      channel_sync_select <= 5'(`MTMC_SYNC_RST);
    end else if (wr_lane0 && aw_addr == `MTMC_OFS_SYNC) begin
      channel_sync_select <= w_data[`MTMC_NUM_CH-1:0];
    end
  end

  // mode select: bit 7 is not stored and always reads one
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || standby_in) begin
      phase_count_enable <= 1'((`MTMC_MODE_RST >> `MTMC_MODE_PHASE_BIT) & 8'h01);
      overflow_flag_direction <= 1'((`MTMC_MODE_RST >> `MTMC_MODE_OVERFLOW_FLAG_DIRECTION_BIT) & 8'h01);
      pulse_mode <= 5'(`MTMC_MODE_RST);
    end else if (wr_lane0 && aw_addr == `MTMC_OFS_MODE) begin
      phase_count_enable <= w_data[`MTMC_MODE_PHASE_BIT];
      overflow_flag_direction <= w_data[`MTMC_MODE_OVERFLOW_FLAG_DIRECTION_BIT];
      pulse_mode <= w_data[`MTMC_NUM_CH-1:0];
    end
  end

  //------------------------------------------------------------
  // synchronous preset and clear
  //------------------------------------------------------------
  assign any_sync_preset = |(preset_req_in & channel_sync_select);
  assign any_sync_clear = |(clear_req_in & channel_sync_select);

  // a synchronised request fans out to every synchronised channel at once
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      preset_out <= '0;
      clear_out <= '0;
    end else begin
      preset_out <= preset_req_in | (channel_sync_select & {5{any_sync_preset}});
      clear_out <= clear_req_in | (channel_sync_select & {5{any_sync_clear}});
    end
  end

  //------------------------------------------------------------
  // channel 2 count source and overflow flag
  //------------------------------------------------------------
  mtmc_phase_decoder u_phase_decoder (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(phase_count_enable),
    .phase_a_in(phase_input_a_in),
    .phase_b_in(phase_input_b_in),
    .count_up_out(dec_up),
    .count_down_out(dec_down)
  );

  // phase mode takes the counter away from the normal tick source
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ch2_count_up_out <= 1'b0;
      ch2_count_down_out <= 1'b0;
    end else if (phase_count_enable) begin
      ch2_count_up_out <= dec_up;
      ch2_count_down_out <= dec_down;
    end else begin
      ch2_count_up_out <= ch2_normal_tick_in;
      ch2_count_down_out <= 1'b0;
    end
  end

  // underflow raises the flag only when the direction bit is clear
  assign next_ovf_set = ch2_overflow_in | (ch2_underflow_in & ~overflow_flag_direction);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      overflow_flag_set_out <= 1'b0;
    end else begin
      overflow_flag_set_out <= next_ovf_set;
    end
  end

  //------------------------------------------------------------
  // pulse outputs
  //------------------------------------------------------------
  assign comb_override = (comb_mode_in == MTMC_COMB_COMPL)
    || (comb_mode_in == MTMC_COMB_RESET_SYNC);
  assign pwm_enable_eff = pulse_mode & ~{comb_override, comb_override, 3'h0};

  mtmc_pwm_out #(
    .NUM_CH(`MTMC_NUM_CH)
  ) u_pwm_out (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(pwm_enable_eff),
    .match_a_in(match_a_in),
    .match_b_in(match_b_in),
    .pin_out(compare_pin_a_out),
    .pin_oe_n_out(compare_pin_a_oe_n_out)
  );

  //------------------------------------------------------------
  // interrupts
  //------------------------------------------------------------
  assign next_events = {any_sync_preset | any_sync_clear, next_ovf_set};

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      irq_status <= '0;
    end else if (wr_lane0 && aw_addr == `MTMC_OFS_STAT) begin
      irq_status <= (irq_status & ~w_data[`MTMC_STAT_W-1:0]) | next_events;
    end else begin
      irq_status <= irq_status | next_events;
    end
  end

  // mask register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      irq_mask <= '0;
    end else if (wr_lane0 && aw_addr == `MTMC_OFS_MASK) begin
      irq_mask <= w_data[`MTMC_STAT_W-1:0];
    end
  end

  assign irq_out = |(irq_status & irq_mask);

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sync_rsv_ones_a: assert property (s_axi_arvalid_in && s_axi_arready_out
      && s_axi_araddr_in == `MTMC_OFS_SYNC |=> s_axi_rdata_out[7:5] == 3'h7)
    else $error("sync register reserved bits not read as one");
  mode_rsv_one_a: assert property (s_axi_arvalid_in && s_axi_arready_out
      && s_axi_araddr_in == `MTMC_OFS_MODE |=> s_axi_rdata_out[7])
    else $error("mode register bit 7 not read as one");
  standby_init_a: assert property (standby_in |=> channel_sync_select == 5'h00
      && pulse_mode == 5'h00 && !phase_count_enable)
    else $error("standby did not restore initial values");
  sync_fanout_a: assert property ((preset_req_in & channel_sync_select) != 5'h00
      |=> (preset_out & $past(channel_sync_select)) == $past(channel_sync_select))
    else $error("synchronised preset did not reach every synced channel");
  indep_channel_a: assert property (any_sync_clear == 1'b0
      |=> clear_out == $past(clear_req_in))
    else $error("independent clear altered by sync logic");
  phase_down_a: assert property (phase_count_enable && $rose(phase_input_a_in)
      && !phase_input_b_in && $stable(phase_input_b_in) && $stable(phase_count_enable)
      |-> ##2 ch2_count_down_out && !ch2_count_up_out)
    else $error("phase rise of A with B low did not count down");
  phase_up_a: assert property (phase_count_enable && $fell(phase_input_a_in)
      && !phase_input_b_in && $stable(phase_input_b_in) && $stable(phase_count_enable)
      |-> ##2 ch2_count_up_out && !ch2_count_down_out)
    else $error("phase fall of A with B low did not count up");
  tick_ignored_a: assert property (phase_count_enable && $past(phase_count_enable)
      && $stable(phase_input_a_in) && $stable(phase_input_b_in)
      |-> ##2 !ch2_count_up_out || !$past(phase_count_enable))
    else $error("normal tick leaked into phase counting");
  ovf_direction_a: assert property (ch2_underflow_in && !ch2_overflow_in
      |=> overflow_flag_set_out == !$past(overflow_flag_direction))
    else $error("overflow flag ignored direction setting");
  pwm_override_a: assert property (comb_override ##1 comb_override
      |-> compare_pin_a_oe_n_out[4:3] == 2'h3)
    else $error("combination mode did not mask pulse enables 3 and 4");
  pwm_level_a: assert property ((pwm_enable_eff & match_a_in & ~match_b_in) != 5'h00
      |=> (compare_pin_a_out & $past(pwm_enable_eff & match_a_in & ~match_b_in))
      == $past(pwm_enable_eff & match_a_in & ~match_b_in))
    else $error("pulse pin did not rise on match with A");
  pwm_enable_a: assert property (pulse_mode[0] ##1 pulse_mode[0]
      |-> !compare_pin_a_oe_n_out[0])
    else $error("pulse mode bit did not drive the pin");
endmodule

// ### tb/mtmc_tb.sv
// self-checking bench of the timer mode-control block
`timescale 1ns/1ps
`include "mtmc_defines.svh"
module tb;
  import mtmc_pkg::*;
  logic sys_clk_in, rst_n_in, standby_in;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, comb_v;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  mtmc_chan_vec_type pre_req, clr_req, pre_q, clr_q, ma, mb, pin, pin_oe_n;
  logic ph_a, ph_b, tick, cnt_up, cnt_dn, ovf, unf, ovf_set, irq;
  int error_cnt, n_tests;
  int m_sync, m_mode, m_stat, m_mask, m_pin, n_up, n_dn, e_up, e_dn;

  mtmc_timer_mode_ctrl u_dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .standby_in(standby_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .preset_req_in(pre_req), .clear_req_in(clr_req), .preset_out(pre_q), .clear_out(clr_q),
    .phase_input_a_in(ph_a), .phase_input_b_in(ph_b), .ch2_normal_tick_in(tick),
    .ch2_count_up_out(cnt_up), .ch2_count_down_out(cnt_dn), .ch2_overflow_in(ovf),
    .ch2_underflow_in(unf), .overflow_flag_set_out(ovf_set),
    .comb_mode_in(mtmc_comb_mode_type'(comb_v)), .match_a_in(ma), .match_b_in(mb),
    .compare_pin_a_out(pin), .compare_pin_a_oe_n_out(pin_oe_n), .irq_out(irq)
  );

  // free-running system clock
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  //------------------------------------------------------------
  // checking and bus tasks
  //------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // a handshake that never completes ends the run
  task automatic hang();
    chk("handshake wait", 32'h0000_0001, 32'h0000_0000);
    results();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic at, wt;
    at = 1'b0;
    wt = 1'b0;
    @(posedge sys_clk_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int t = 0; t < 40; t++) begin
      @(posedge sys_clk_in);
      if (bvalid === 1'b1 && at && wt) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
      if (awready === 1'b1 && !at) begin
        at = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wt) begin
        wt = 1'b1;
        wvalid <= 1'b0;
      end
    end
    hang();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int t = 0; t < 40; t++) begin
      @(posedge sys_clk_in);
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end else if (arready === 1'b1 && arvalid === 1'b1) begin
        arvalid <= 1'b0;
      end
    end
    hang();
  endtask

  //------------------------------------------------------------
  // register model
  //------------------------------------------------------------
  function automatic logic [31:0] mrd(input logic [7:0] a);
    case (a)
      `MTMC_OFS_SYNC: return 32'(m_sync);
      `MTMC_OFS_MODE: return 32'(m_mode);
      `MTMC_OFS_STAT: return 32'(m_stat);
      `MTMC_OFS_MASK: return 32'(m_mask);
      default: return 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [1:0] eresp(input logic [7:0] a);
    if (a inside {`MTMC_OFS_SYNC, `MTMC_OFS_MODE, `MTMC_OFS_STAT, `MTMC_OFS_MASK}) begin
      return `MTMC_RESP_OKAY;
    end
    return `MTMC_RESP_SLVERR;
  endfunction

  // write a register and follow it in the model; reserved bits stay one
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", eresp(a), r);
    case (a)
      `MTMC_OFS_SYNC: m_sync = int'(d[4:0]) | 8'he0;
      `MTMC_OFS_MODE: m_mode = int'(d[6:0]) | 8'h80;
      `MTMC_OFS_STAT: m_stat = m_stat & ~int'(d[1:0]);
      `MTMC_OFS_MASK: m_mask = int'(d[1:0]);
      default: ;
    endcase
  endtask

  // read back and compare every bit with the model
  task automatic rchk(input logic [7:0] a);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk("rresp", eresp(a), r);
    chk("rdata", mrd(a), d);
  endtask

  // random counter-side traffic, compared cycle by cycle with the model
  task automatic run(input int n);
    logic [4:0] p, c, a, b, en, ep, ec, eoe;
    logic [1:0] cb;
    logic t, o, u, eo, up;
    int k;
    ep = 5'h00;
    ec = 5'h00;
    eo = 1'b0;
    eoe = ~(5'(m_mode) & ((comb_v >= 2'h2) ? 5'h07 : 5'h1f));
    for (int i = 0; i < n + 6; i++) begin
      k = (i < n) ? 1 : 0;
      p = k ? 5'($urandom & $urandom) : 5'h00;
      c = k ? 5'($urandom & $urandom) : 5'h00;
      a = k ? 5'($urandom) : 5'h00;
      b = k ? 5'($urandom & $urandom) : 5'h00;
      {t, o, u} = k ? 3'($urandom & $urandom) : 3'h0;
      cb = 2'($urandom);
      @(posedge sys_clk_in);
      pre_req <= p;
      clr_req <= c;
      ma <= a;
      mb <= b;
      tick <= t;
      ovf <= o;
      unf <= u;
      comb_v <= cb;
      if (k && i % 6 == 0) begin
        if ($urandom & 1) begin
          up = (~ph_a) == ph_b;
          ph_a <= ~ph_a;
        end else begin
          up = (~ph_b) != ph_a;
          ph_b <= ~ph_b;
        end
        e_up += (m_mode[6] && up) ? 1 : 0;
        e_dn += (m_mode[6] && !up) ? 1 : 0;
      end
      e_up += (!m_mode[6] && t) ? 1 : 0;
      @(negedge sys_clk_in);
      n_up += (cnt_up === 1'b1) ? 1 : 0;
      n_dn += (cnt_dn === 1'b1) ? 1 : 0;
      chk("preset", ep, pre_q);
      chk("clear", ec, clr_q);
      chk("overflow set", eo, ovf_set);
      chk("pulse pin", m_pin, pin);
      chk("pulse oe", eoe, pin_oe_n);
      ep = p | (((p & 5'(m_sync)) != 5'h00) ? 5'(m_sync) : 5'h00);
      ec = c | (((c & 5'(m_sync)) != 5'h00) ? 5'(m_sync) : 5'h00);
      eo = o | (u & ~m_mode[5]);
      // status bit 1 records any synchronised preset or clear
      m_stat = m_stat | eo | ((((p | c) & 5'(m_sync)) != 5'h00) ? 2 : 0);
      en = 5'(m_mode) & ((cb >= 2'h2) ? 5'h07 : 5'h1f);
      eoe = ~en;
      m_pin = (m_pin | (en & a)) & ~(en & b);
    end
  endtask

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [7:0] a;
    {rst_n_in, standby_in, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata, wstrb, comb_v} = 54'h0;
    {pre_req, clr_req, ma, mb, ph_a, ph_b, tick, ovf, unf} = 25'h0;
    {error_cnt, n_tests, m_stat, m_mask, m_pin} = 160'h0;
    m_sync = 8'he0;
    m_mode = 8'h80;
    d = $urandom(32'h0000_8c4a);
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rchk(`MTMC_OFS_SYNC);
    rchk(`MTMC_OFS_MODE);
    rchk(`MTMC_OFS_MASK);
    // random accesses, one address past the map
    for (int i = 0; i < 12; i++) begin
      a = 8'($urandom_range(0, 4)) << 2;
      wreg(a, $urandom);
      rchk(a);
    end
    // standby puts both selects back to their initial values
    wreg(`MTMC_OFS_SYNC, 32'h0000_001f);
    wreg(`MTMC_OFS_MODE, 32'h0000_007f);
    @(posedge sys_clk_in);
    standby_in <= 1'b1;
    @(posedge sys_clk_in);
    standby_in <= 1'b0;
    m_sync = 8'he0;
    m_mode = 8'h80;
    rchk(`MTMC_OFS_SYNC);
    rchk(`MTMC_OFS_MODE);
    // every pairing of phase counting and flag direction
    for (int k = 0; k < 6; k++) begin
      wreg(`MTMC_OFS_MASK, (k == 0) ? 32'h0000_0003 : 32'h0000_0002);
      wreg(`MTMC_OFS_SYNC, $urandom);
      d = $urandom;
      d[6] = k[0];
      d[5] = k[1];
      wreg(`MTMC_OFS_MODE, d);
      {n_up, n_dn, e_up, e_dn} = 128'h0;
      run(40);
      chk("count up", e_up, n_up);
      chk("count down", e_dn, n_dn);
      chk("irq", |(m_stat & m_mask), irq);
      rchk(`MTMC_OFS_STAT);
      wreg(`MTMC_OFS_STAT, 32'h0000_0003);
      chk("irq cleared", 32'h0000_0000, irq);
    end
    results();
  end
endmodule
